// ### cmwm_params.svh
`ifndef CMWM_PARAMS_SVH
`define CMWM_PARAMS_SVH
// Upper ten bits shared by every word-move opcode of this family.
`define CMWM_OPC_HI      10'h22F
// Low six bits of each word-move opcode.
`define CMWM_OPC_E2     6'h19
`define CMWM_OPC_1E     6'h1A
`define CMWM_OPC_11     6'h1B
`define CMWM_OPC_12     6'h1C
`define CMWM_OPC_2E     6'h1D
`define CMWM_OPC_21     6'h1E
`define CMWM_OPC_22     6'h1F
// Reset value of the working registers.
`define CMWM_REG_RST     16'h0000
// Position of the indirect flag in an address word.
`define CMWM_IND_BIT     15
`endif

// ### cmwm_pkg.sv
package cmwm_pkg;
    // Memory map selected for one access.
    typedef enum logic [1:0] {
        CMWM_MAP_EXEC = 2'h0,
        CMWM_MAP_ALT1 = 2'h1,
        CMWM_MAP_ALT2 = 2'h2
    } cmwm_map_t;
    // Sequencer states, one-hot.
    typedef enum logic [4:0] {
        CMWM_ST_IDLE  = 5'h01,
        CMWM_ST_CHECK = 5'h02,
        CMWM_ST_READ  = 5'h04,
        CMWM_ST_WRITE = 5'h08,
        CMWM_ST_DONE  = 5'h10
    } cmwm_state_t;
endpackage

// ### cmwm_dec_if.sv
`timescale 1ns/1ns
// Carries one instruction word to the decoder and its decode back.
interface cmwm_dec_if;
    import cmwm_pkg::*;
    logic [15:0] instr;  // Instruction word under decode.
    logic        valid;  // Word is one of the seven word moves.
    cmwm_map_t   src;    // Source map.
    cmwm_map_t   dst;    // Destination map.
    logic        chk_a;  // Source register needs the base-relative check.
    logic        chk_b;  // Destination register needs the base-relative check.
    modport dec (input instr, output valid, src, dst, chk_a, chk_b);
    modport use_side (output instr, input valid, src, dst, chk_a, chk_b);
endinterface

// ### cmwm_decode.sv
`timescale 1ns/1ns
`include "cmwm_params.svh"
// Pure decode of the word-move opcodes into map selections.
module cmwm_decode (
    cmwm_dec_if.dec d
);
    import cmwm_pkg::*;
    wire       hi_match = (d.instr[15:6] == `CMWM_OPC_HI);
    wire [5:0] lo       = d.instr[5:0];
    // Map pair for each low field; the execute-to-execute forms are not ours.
    assign d.valid = hi_match && (lo >= `CMWM_OPC_E2) && (lo <= `CMWM_OPC_22);
    assign d.src = (lo == `CMWM_OPC_E2) ? CMWM_MAP_EXEC :
                   (lo <= `CMWM_OPC_12) ? CMWM_MAP_ALT1 : CMWM_MAP_ALT2;
    assign d.dst = (lo == `CMWM_OPC_1E || lo == `CMWM_OPC_2E) ? CMWM_MAP_EXEC :
                   (lo == `CMWM_OPC_11 || lo == `CMWM_OPC_21) ? CMWM_MAP_ALT1 :
                   CMWM_MAP_ALT2;
    // Only a move that touches the execute map checks its execute-side register.
    assign d.chk_a = (d.src == CMWM_MAP_EXEC);
    assign d.chk_b = (d.dst == CMWM_MAP_EXEC);
endmodule // cmwm_decode

// ### cmwm_move.sv
`timescale 1ns/1ns
`include "cmwm_params.svh"
// Contract
// - Decode seven word-move opcodes into map pairs.
// - A source, B destination, X word count.
// - A ends one past last source word.
// - B ends one past last destination word.
// - X ends at zero.
// - Segmented mode, execute source: check A first.
// - Segmented mode, execute destination: check B first.
// - Checked register ends relative plus original count.
// - Interruptible; progress kept only in A, B, X.
// - Alternate maps disable register addressing and checking.
module cmwm_move (
    input  wire logic               clk_sys_i,     // Processor clock.
    input  wire logic               sys_rst_i,     // Synchronous reset, active high.
    input  wire logic               start_i,       // Execute the instruction word now.
    input  wire logic [15:0]        instr_i,       // Instruction word.
    input  wire logic [15:0]        reg_a_i,       // Accumulator A at start.
    input  wire logic [15:0]        reg_b_i,       // Accumulator B at start.
    input  wire logic [15:0]        reg_x_i,       // Index X at start.
    input  wire logic               seg_code_mode_i, // Segmented code mode is on.
    input  wire logic               irq_pend_i,    // An interrupt is pending.
    input  wire logic               chk_ack_i,     // Base-relative check finished.
    input  wire logic [15:0]        chk_rel_i,     // Base-relative address returned.
    input  wire logic               mem_ack_i,     // Memory finished the access.
    input  wire logic [15:0]        mem_rdata_i,   // Read data.
    output logic                    busy_o,        // A move is in progress.
    output logic                    done_o,        // One-cycle end of instruction.
    output logic                    intr_o,        // Ended early for an interrupt.
    output logic                    illegal_o,     // Start refused: not a word move.
    output logic [15:0]             reg_a_o,       // Accumulator A.
    output logic [15:0]             reg_b_o,       // Accumulator B.
    output logic [15:0]             reg_x_o,       // Index X.
    output logic                    chk_req_o,     // Base-relative check request.
    output logic [15:0]             chk_addr_o,    // Address to check.
    output logic                    mem_req_o,     // Memory access request.
    output logic                    mem_we_o,      // Access is a write.
    output cmwm_pkg::cmwm_map_t     mem_map_o,     // Map for the access.
    output logic                    mem_regs_en_o, // Locations 0 and 1 reach A and B.
    output logic [15:0]             mem_addr_o,    // Word address.
    output logic [15:0]             mem_wdata_o    // Write data.
);
    import cmwm_pkg::*;

    cmwm_dec_if  dec_if ();                    // Link to the opcode decoder.
    cmwm_state_t state_q;                      // Sequencer state.
    cmwm_map_t   src_q;                        // Latched source map.
    cmwm_map_t   dst_q;                        // Latched destination map.
    logic        chk_a_q;                      // A must be checked this move.
    logic        chk_b_q;                      // B must be checked this move.

    cmwm_decode u_dec (
        .d (dec_if.dec)
    );
    assign dec_if.instr = instr_i;

    // A start is taken or refused only when idle; a non-move word is refused.
    wire take    = start_i && (state_q == CMWM_ST_IDLE) && dec_if.valid;
    wire refuse  = start_i && (state_q == CMWM_ST_IDLE) && !dec_if.valid;
    // Checking is gated by mode and by which side uses the execute map.
    wire need_a  = seg_code_mode_i && dec_if.chk_a;
    wire need_b  = seg_code_mode_i && dec_if.chk_b;
    wire rd_done = (state_q == CMWM_ST_READ) && mem_ack_i;
    wire wr_done = (state_q == CMWM_ST_WRITE) && mem_ack_i;
    wire last    = (reg_x_o == 16'h0001);
    // The interrupt is honoured only between words, so A, B and X always agree.
    wire yield   = wr_done && !last && irq_pend_i;

    // Sequencer.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= CMWM_ST_IDLE;
        end else begin
            case (state_q)
                CMWM_ST_IDLE: begin
                    if (take && (need_a || need_b)) begin
                        state_q <= CMWM_ST_CHECK;
                    end else if (take) begin
                        // A zero count skips straight to the end.
                        state_q <= (reg_x_i == 16'h0000) ? CMWM_ST_DONE : CMWM_ST_READ;
                    end
                end
                CMWM_ST_CHECK: begin
                    if (chk_ack_i) begin
                        state_q <= (reg_x_o == 16'h0000) ? CMWM_ST_DONE : CMWM_ST_READ;
                    end
                end
                CMWM_ST_READ: begin
                    if (mem_ack_i) begin
                        state_q <= CMWM_ST_WRITE;
                    end
                end
                CMWM_ST_WRITE: begin
                    if (mem_ack_i) begin
                        state_q <= (last || yield) ? CMWM_ST_DONE : CMWM_ST_READ;
                    end
                end
                CMWM_ST_DONE: begin
                    state_q <= CMWM_ST_IDLE;
                end
                default: begin
                    state_q <= CMWM_ST_IDLE;
                end
            endcase
        end
    end

    // Working registers A, B and X; they hold all progress of the move.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reg_a_o <= `CMWM_REG_RST;
            reg_b_o <= `CMWM_REG_RST;
            reg_x_o <= `CMWM_REG_RST;
        end else if (take) begin
            reg_a_o <= reg_a_i;
            reg_b_o <= reg_b_i;
            reg_x_o <= reg_x_i;
        end else if (state_q == CMWM_ST_CHECK && chk_ack_i) begin
            // The relative form is stepped by the count, giving relative plus count.
            if (chk_a_q) begin
                reg_a_o <= chk_rel_i;
            end
            if (chk_b_q) begin
                reg_b_o <= chk_rel_i;
            end
        end else if (wr_done) begin
            reg_a_o <= reg_a_o + 16'h0001;
            reg_b_o <= reg_b_o + 16'h0001;
            reg_x_o <= reg_x_o - 16'h0001;
        end
    end

    // Latched decode of the move being run.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            src_q   <= CMWM_MAP_EXEC;
            dst_q   <= CMWM_MAP_EXEC;
            chk_a_q <= 1'b0;
            chk_b_q <= 1'b0;
        end else if (take) begin
            src_q   <= dec_if.src;
            dst_q   <= dec_if.dst;
            chk_a_q <= need_a;
            chk_b_q <= need_b;
        end
    end

    // Check request; only one side can be the execute map in these moves.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            chk_req_o  <= 1'b0;
            chk_addr_o <= 16'h0000;
        end else begin
            chk_req_o  <= (take && (need_a || need_b)) ||
                          (state_q == CMWM_ST_CHECK && !chk_ack_i);
            if (take) begin
                chk_addr_o <= need_a ? reg_a_i : reg_b_i;
            end
        end
    end

    // Memory request: read at A through the source map, then write at B.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            mem_req_o     <= 1'b0;
            mem_we_o      <= 1'b0;
            mem_map_o     <= CMWM_MAP_EXEC;
            mem_regs_en_o <= 1'b1;
            mem_addr_o    <= 16'h0000;
            mem_wdata_o   <= 16'h0000;
        end else begin
            mem_req_o <= (state_q == CMWM_ST_READ && !mem_ack_i) ||
                         (state_q == CMWM_ST_WRITE && !mem_ack_i) || rd_done;
            if (rd_done) begin
                mem_we_o      <= 1'b1;
                mem_map_o     <= dst_q;
                mem_regs_en_o <= (dst_q == CMWM_MAP_EXEC);
                mem_addr_o    <= reg_b_o;
                mem_wdata_o   <= mem_rdata_i;
            end else if (state_q == CMWM_ST_READ) begin
                mem_we_o      <= 1'b0;
                mem_map_o     <= src_q;
                mem_regs_en_o <= (src_q == CMWM_MAP_EXEC);
                mem_addr_o    <= reg_a_o;
            end else if (state_q != CMWM_ST_WRITE) begin
                mem_we_o      <= 1'b0;
            end
        end
    end

    // Status outputs; busy lasts from the taken start to the done pulse.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            intr_o    <= 1'b0;
            illegal_o <= 1'b0;
        end else begin
            busy_o    <= take || (busy_o && !(state_q == CMWM_ST_DONE));
            done_o    <= (state_q == CMWM_ST_DONE);
            illegal_o <= refuse;
            if (yield) begin
                intr_o <= 1'b1;
            end else if (take) begin
                intr_o <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    decode_move_words_exec_to_alt_two_a: assert property (take && instr_i[5:0] == `CMWM_OPC_E2 |=>
        src_q == CMWM_MAP_EXEC && dst_q == CMWM_MAP_ALT2)
        else $error("exec to second map decoded wrongly");
    read_addr_a: assert property (mem_req_o && !mem_we_o |->
        mem_addr_o == reg_a_o && mem_map_o == src_q)
        else $error("read not at A in source map");
    a_step_a: assert property (wr_done |=> reg_a_o == $past(reg_a_o) + 16'h0001)
        else $error("A did not advance by one");
    b_step_a: assert property (wr_done |=> reg_b_o == $past(reg_b_o) + 16'h0001)
        else $error("B did not advance by one");
    x_zero_a: assert property (done_o && !intr_o |-> reg_x_o == 16'h0000)
        else $error("X not zero at completion");
    chk_src_a: assert property (take && need_a |=> ##1 chk_req_o &&
        chk_addr_o == $past(reg_a_i, 2))
        else $error("A not checked");
    chk_dst_a: assert property (take && need_b && !need_a |=> ##1 chk_req_o &&
        chk_addr_o == $past(reg_b_i, 2))
        else $error("B not checked");
    no_chk_a: assert property (take && !dec_if.chk_a && !dec_if.chk_b |=>
        !chk_req_o [*2])
        else $error("check made for alternate-only move");
    alt_regs_a: assert property (mem_req_o && mem_map_o != CMWM_MAP_EXEC |->
        !mem_regs_en_o)
        else $error("register addressing in alternate map");
    yield_a: assert property (yield |=> state_q == CMWM_ST_DONE ##1
        done_o && intr_o && reg_x_o != 16'h0000)
        else $error("interrupt exit wrong");
    x_step_a: assert property (wr_done |=> reg_x_o == $past(reg_x_o) - 16'h0001)
        else $error("X did not count down");

    full_move_c: cover property (wr_done && last ##2 done_o && !intr_o);
    intr_move_c: cover property (done_o && intr_o);
    checked_move_c: cover property (chk_req_o ##[1:20] done_o);
endmodule // cmwm_move

// ### cmwm_mem_model.sv
`timescale 1ns/1ns
// Memory behind the three maps plus the base-relative check responder.
module cmwm_mem_model #(
    parameter logic [15:0] BASE = 16'h0010 // Segment base removed by the check.
) (
    input  wire logic                clk_sys_i,   // Processor clock.
    input  wire logic [1:0]          lat_i,       // Answer delay in cycles, 1 to 3.
    input  wire logic                mem_req_i,   // Access request.
    input  wire logic                mem_we_i,    // Access is a write.
    input  wire cmwm_pkg::cmwm_map_t mem_map_i,   // Map of the access.
    input  wire logic [15:0]         mem_addr_i,  // Word address.
    input  wire logic [15:0]         mem_wdata_i, // Write data.
    input  wire logic                chk_req_i,   // Check request.
    input  wire logic [15:0]         chk_addr_i,  // Address to check.
    output logic                     mem_ack_o,   // Access done.
    output logic [15:0]              mem_rdata_o, // Read data.
    output logic                     chk_ack_o,   // Check done.
    output logic [15:0]              chk_rel_o    // Relative address.
);
    import cmwm_pkg::*;
    logic [15:0] mem [0:2][0:63]; // One small store per map, low six address bits.
    logic [1:0]  mcnt_q = 2'h0;   // Memory wait counter.
    logic [1:0]  ccnt_q = 2'h0;   // Check wait counter.
    int          n_acc;           // Accesses served since the last fill.
    int          n_chk;           // Checks served since the last fill.
    initial mem_ack_o = 1'b0;
    initial chk_ack_o = 1'b0;
    initial mem_rdata_o = 16'h5A5A;
    initial chk_rel_o = 16'hA5A5;
    // Loads a pattern that names map and address in every word.
    task automatic fill();
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 64; i++) mem[m][i] = 16'hA000 + 16'(m * 256 + i);
        end
        n_acc = 0;
        n_chk = 0;
    endtask
    // Data lines toggle outside the answer cycle so stale values never pass.
    always @(posedge clk_sys_i) begin
        mem_ack_o <= 1'b0;
        chk_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        chk_rel_o <= ~chk_rel_o;
        if (mem_req_i && !mem_ack_o) begin
            mcnt_q <= (mcnt_q == lat_i - 2'h1) ? 2'h0 : mcnt_q + 2'h1;
            if (mcnt_q == lat_i - 2'h1) begin
                mem_ack_o <= 1'b1;
                n_acc <= n_acc + 1;
                if (mem_we_i) mem[mem_map_i][mem_addr_i[5:0]] <= mem_wdata_i;
                else mem_rdata_o <= mem[mem_map_i][mem_addr_i[5:0]];
            end
        end
        if (chk_req_i && !chk_ack_o) begin
            ccnt_q <= (ccnt_q == lat_i - 2'h1) ? 2'h0 : ccnt_q + 2'h1;
            if (ccnt_q == lat_i - 2'h1) begin
                chk_ack_o <= 1'b1;
                n_chk <= n_chk + 1;
                chk_rel_o <= chk_addr_i - BASE;
            end
        end
    end
endmodule // cmwm_mem_model

// ### testbench.sv
`timescale 1ns/1ns
`include "cmwm_params.svh"
// Self-checking bench for the cross-map word mover.
module testbench;
    import cmwm_pkg::*;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, seg = 1'b0, irq = 1'b0;
    logic [15:0] instr = 16'h0000, a_in = 16'h0000, b_in = 16'h0000, x_in = 16'h0000;
    logic [1:0] lat = 2'h1;
    logic busy, done, intr, ill, creq, cack, mreq, mwe, men, mack;
    logic [15:0] ra, rb, rx, caddr, crel, maddr, mwd, mrd;
    cmwm_map_t mmap;
    int failures = 0, samples_checked = 0, cycles = 0;
    logic [5:0] opc [7] = '{`CMWM_OPC_E2, `CMWM_OPC_1E, `CMWM_OPC_11, `CMWM_OPC_12,
                            `CMWM_OPC_2E, `CMWM_OPC_21, `CMWM_OPC_22};
    int srcm [7] = '{0, 1, 1, 1, 2, 2, 2};
    int dstm [7] = '{2, 0, 1, 2, 0, 1, 2};
    cmwm_move dut (.clk_sys_i(clk), .sys_rst_i(rst), .start_i(start), .instr_i(instr),
        .reg_a_i(a_in), .reg_b_i(b_in), .reg_x_i(x_in), .seg_code_mode_i(seg),
        .irq_pend_i(irq), .chk_ack_i(cack), .chk_rel_i(crel), .mem_ack_i(mack),
        .mem_rdata_i(mrd), .busy_o(busy), .done_o(done), .intr_o(intr), .illegal_o(ill),
        .reg_a_o(ra), .reg_b_o(rb), .reg_x_o(rx), .chk_req_o(creq), .chk_addr_o(caddr),
        .mem_req_o(mreq), .mem_we_o(mwe), .mem_map_o(mmap), .mem_regs_en_o(men),
        .mem_addr_o(maddr), .mem_wdata_o(mwd));
    cmwm_mem_model model (.clk_sys_i(clk), .lat_i(lat), .mem_req_i(mreq), .mem_we_i(mwe),
        .mem_map_i(mmap), .mem_addr_i(maddr), .mem_wdata_i(mwd), .chk_req_i(creq),
        .chk_addr_i(caddr), .mem_ack_o(mack), .mem_rdata_o(mrd), .chk_ack_o(cack),
        .chk_rel_o(crel));
    initial forever #4 clk = ~clk;
    // Compares one value and reports a mismatch at once.
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Issues one instruction and waits a bounded time for its end.
    task automatic run(input logic [15:0] ins, aa, bb, xx, input logic sg);
        int i;
        @(posedge clk) #1;
        {instr, a_in, b_in, x_in, seg, start} = {ins, aa, bb, xx, sg, 1'b1};
        @(posedge clk) #1;
        start = 1'b0;
        cmp({busy, rx[14:0]}, {1'b1, xx[14:0]}, "busy X load");
        for (i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk) #1;
        cmp({14'h0, done, busy}, 16'h0002, "done");
    endtask
    // Every opcode, with A at location 0 so alternate maps must reach memory.
    task automatic t_opcodes();
        for (int k = 0; k < 7; k++) begin
            model.fill();
            run({`CMWM_OPC_HI, opc[k]}, 16'h0000, 16'h0020, 16'h0003, 1'b0);
            cmp(ra, 16'h0003, "A end");
            cmp(rb, 16'h0023, "B end");
            cmp(rx, 16'h0000, "X end");
            cmp(16'(model.n_acc), 16'h0006, "accesses");
            for (int j = 0; j < 3; j++)
                cmp(model.mem[dstm[k]][32 + j], 16'hA000 + 16'(srcm[k] * 256 + j), "data");
        end
    endtask
    // Segmented mode: only the execute-map register is checked and rebased.
    task automatic t_check();
        logic [15:0] ea [3] = '{16'h0022, 16'h000A, 16'h000A};
        logic [15:0] eb [3] = '{16'h0032, 16'h0022, 16'h0032};
        logic [15:0] en [3] = '{16'h0001, 16'h0001, 16'h0000};
        int kk [3] = '{0, 1, 2};
        for (int k = 0; k < 3; k++) begin
            model.fill();
            run({`CMWM_OPC_HI, opc[kk[k]]}, k == 0 ? 16'h0030 : 16'h0008, 16'h0030, 16'h0002,
                1'b1);
            cmp(ra, ea[k], "A rebased");
            cmp(rb, eb[k], "B rebased");
            cmp(16'(model.n_chk), en[k], "checks");
            // The words must move through the rebased address on whichever side was checked, if any.
            for (int j = 0; j < 2; j++)
                cmp(model.mem[dstm[k]][(k == 1 ? 32 : 48) + j],
                    16'hA000 + 16'(srcm[k] * 256 + (k == 0 ? 32 : 8) + j), "rebased data");
        end
    endtask
    // Zero count ends without any memory access.
    task automatic t_zero();
        model.fill();
        run({`CMWM_OPC_HI, `CMWM_OPC_22}, 16'h0005, 16'h0025, 16'h0000, 1'b0);
        cmp(ra, 16'h0005, "A zero");
        cmp(rb, 16'h0025, "B zero");
        cmp(16'(model.n_acc), 16'h0000, "zero accesses");
    endtask
    // A bad-word start while a move runs is ignored, not refused; the move ends as issued.
    task automatic t_busy();
        model.fill();
        @(posedge clk) #1;
        {instr, a_in, b_in, x_in, seg, start} = {`CMWM_OPC_HI, `CMWM_OPC_21, 16'h0004,
                                                 16'h0024, 16'h0002, 1'b0, 1'b1};
        @(posedge clk) #1;
        {instr, a_in} = {16'h0BD9, 16'h0030};
        repeat (2) @(posedge clk) #1;
        cmp({15'h0, ill}, 16'h0000, "busy refusal");
        start = 1'b0;
        for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk) #1;
        cmp({15'h0, done}, 16'h0001, "busy done");
        cmp({ra[7:0], rb[7:0]}, 16'h0626, "busy A B");
        cmp(model.mem[1][37], 16'hA205, "busy data");
    endtask
    // Words outside the family are refused with a pulse.
    task automatic t_illegal();
        logic [15:0] bad [2] = '{16'h8BD8, 16'h0BD9};
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) #1;
            {instr, start} = {bad[k], 1'b1};
            @(posedge clk) #1;
            start = 1'b0;
            cmp({14'h0, ill, busy}, 16'h0002, "refusal");
        end
    endtask
    // Interrupt after one word, then reissue with the returned registers.
    task automatic t_irq();
        model.fill();
        lat = 2'h3;
        irq = 1'b1;
        run({`CMWM_OPC_HI, `CMWM_OPC_12}, 16'h0000, 16'h0020, 16'h0003, 1'b0);
        irq = 1'b0;
        cmp({intr, 3'h0, ra[3:0], rb[7:0]}, 16'h8121, "intr A B");
        cmp(rx, 16'h0002, "intr X");
        run({`CMWM_OPC_HI, `CMWM_OPC_12}, ra, rb, rx, 1'b0);
        cmp({intr, 3'h0, ra[3:0], rb[7:0]}, 16'h0323, "resume A B");
        for (int j = 0; j < 3; j++)
            cmp(model.mem[2][32 + j], 16'hA100 + 16'(j), "resume data");
        lat = 2'h1;
    endtask
    // Alternate-map accesses must not reach the register file.
    always @(posedge clk) begin
        if (mreq === 1'b1)
            cmp({15'h0, men}, {15'h0, mmap == CMWM_MAP_EXEC}, "regs enable");
    end
    // Ends the run with the counts and the verdict.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Cuts a hang short well past the expected run length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("ERROR %0t run timed out", $time);
            wrap_up();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        t_opcodes();
        t_check();
        t_zero();
        t_busy();
        t_illegal();
        t_irq();
        wrap_up();
    end
endmodule // testbench
